/* dv/tb_tpcu_top.sv */
// Self-checking bench for the timer unit, two channels, fixed seed.
// Assumes the pin model closes the pin loop and makes the count clocks.
`timescale 1ns/10ps
module tb_tpcu_top;
	import tpcu_pkg::*;
	localparam int unsigned N = 2;
	logic                 sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, debug_halt = 1'b0;
	logic                 count_write = 1'b0, overflow_clr = 1'b0, ext_clk, fix_clk, b;
	tpcu_cfg_t            cfg = '0;
	tpcu_ch_cfg_t [N-1:0] ch_cfg = '0;
	logic [N-1:0]         ch_wr_en = '0, ch_flag_clr = '0, src = '0, pin_in, pin_out;
	logic [N-1:0]         pin_oe, claim, flag;
	logic [N-1:0][15:0]   match = '0, ch_value;
	logic [15:0]          count_value, v, w;
	logic                 count_down, overflow_flag;
	int                   error_cnt = 0, checks = 0, seed = 32'h279e8056, n, i, e;

	tpcu_top #(.NUM_CH(N)) u_tpcu_top (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
		.debug_halt(debug_halt), .cfg(cfg), .count_write(count_write),
		.overflow_clr(overflow_clr), .external_count_clock(ext_clk), .fixed_clock(fix_clk),
		.ch_cfg(ch_cfg), .ch_wr_en(ch_wr_en), .channel_match_value(match),
		.ch_flag_clr(ch_flag_clr), .timer_channel_pin_in(pin_in), .count_value(count_value),
		.count_down(count_down), .overflow_flag(overflow_flag), .ch_value(ch_value),
		.ch_flag(flag), .timer_channel_pin_out(pin_out), .timer_channel_pin_oe(pin_oe),
		.timer_channel_pin_claim(claim));
	tpcu_pin_model #(.NUM_CH(N)) u_tpcu_pin_model (.src_level(src), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_wire(pin_in), .ext_clk(ext_clk), .fix_clk(fix_clk));

	// 25 MHz bus clock
	always #20 sys_clk = ~sys_clk;

	// ==========================================================
	// Helpers; inputs only change at falling edges
	task automatic cyc(int k);
		repeat (k) @(negedge sys_clk);
	endtask : cyc
	task check(string name, logic [15:0] seen, logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task stop_test();
		if (error_cnt == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	task restart();
		count_write = 1'b1;
		overflow_clr = 1'b1;
		cyc(1);
		count_write = 1'b0;
		overflow_clr = 1'b0;
	endtask : restart
	task wr(int ch, logic [15:0] d);
		match[ch] = d;
		ch_wr_en[ch] = 1'b1;
		cyc(1);
		ch_wr_en[ch] = 1'b0;
	endtask : wr
	// Overflow cleared too, so later period-end checks see a fresh set
	task clr(int ch);
		ch_flag_clr[ch] = 1'b1;
		overflow_clr = 1'b1;
		cyc(1);
		ch_flag_clr[ch] = 1'b0;
		overflow_clr = 1'b0;
	endtask : clr
	// Cycles between two count changes; the first change only aligns
	task interval(output int k);
		for (int j = 0; j < 2; j++) begin
			w = count_value;
			k = 0;
			while (count_value === w && k < 400) begin
				cyc(1);
				k++;
			end
			if (k >= 400) error_cnt++;
		end
	endtask : interval
	task wait_flag(int ch);
		n = 0;
		while (flag[ch] !== 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
		if (n >= 300) error_cnt++;
	endtask : wait_flag
	// High cycles of a pin over len cycles starting at count zero
	task duty(int ch, int len, output int hi);
		n = 0;
		while (count_value !== CNT_RST && n < 300) begin
			cyc(1);
			n++;
		end
		if (n >= 300) error_cnt++;
		hi = 0;
		repeat (len) begin
			hi += int'(pin_out[ch] === 1'b1);
			cyc(1);
		end
	endtask : duty

	// ==========================================================
	// Expectations
	function logic cap_hit(logic [1:0] el, logic rising);
		return el == EDGE_ANY || (rising ? el == EDGE_RISE : el == EDGE_FALL);
	endfunction : cap_hit
	function logic cmp_pin(logic [1:0] el, logic prev);
		case (el)
			ACT_TOGGLE: return ~prev;
			ACT_CLEAR:  return 1'b0;
			ACT_SET:    return 1'b1;
			default:    return prev;
		endcase
	endfunction : cmp_pin
	function int exp_high(logic center, logic low_true, int val, int lim);
		int on, per;
		on = center ? 2 * val : val;
		per = center ? 2 * lim : lim + 1;
		return low_true ? per - on : on;
	endfunction : exp_high

	// ==========================================================
	// Scenarios
	initial begin
		cyc(16);
		reset = 1'b0;
		check("claim", 16'(claim), 16'h0000);
		check("count", count_value, CNT_RST);
		// Counter walk, limit 2
		cfg = '{CLK_BUS, 3'h0, 1'b0, 16'h0002};
		restart();
		for (i = 0; i < 4; i++) begin
			check("walk", count_value, 16'(i % 3));
			check("ovf", 16'(overflow_flag), 16'(i == 3));
			cyc(1);
		end
		// Every prescale tap, free running limit
		cfg.count_limit_value = LIMIT_ZERO;
		for (i = 0; i < 8; i++) begin
			cfg.prescale = 3'(i);
			restart();
			interval(n);
			check("divide", 16'(n), 16'(1 << i));
		end
		cfg.prescale = 3'h0;
		cfg.count_clock_select = CLK_EXT;
		interval(n);
		check("ext", 16'(n), 16'h0008);
		cfg.count_clock_select = CLK_FIXED;
		interval(n);
		check("fixed", 16'(n), 16'h000c);
		// Freeze by debug and by clock enable, random stop point
		cfg.count_clock_select = CLK_BUS;
		restart();
		cyc(1 + ($unsigned($random(seed)) % 50));
		debug_halt = 1'b1;
		cyc(1);
		v = count_value;
		cyc(10);
		check("debug", count_value, v);
		clk_en = 1'b0;
		cyc(4);
		check("stop", count_value, v);
		clk_en = 1'b1;
		// Capture on channel 1 against the frozen count, all edge choices
		for (e = 0; e < 4; e++) begin
			ch_cfg[1] = '{MODE_CAPTURE, 2'(e)};
			cyc(8);
			check("capclaim", 16'(claim[1]), 16'(e != 0));
			for (i = 1; i >= 0; i--) begin
				clr(1);
				src[1] = i[0];
				cyc(8);
				check("cap", 16'(flag[1]), 16'(cap_hit(2'(e), i[0])));
				if (cap_hit(2'(e), i[0])) check("capval", ch_value[1], v);
			end
		end
		// Compare on channel 0, every pin action
		debug_halt = 1'b0;
		cfg.count_limit_value = 16'h0040;
		src[0] = 1'($random(seed));
		for (e = 0; e < 4; e++) begin
			ch_cfg[0] = '{MODE_COMPARE, 2'(e)};
			w = 16'h0004 + 16'($unsigned($random(seed)) % 60);
			wr(0, w);
			restart();
			clr(0);
			b = pin_out[0];
			wait_flag(0);
			check("cmpcnt", count_value, w);
			check("cmpoe", 16'(pin_oe[0]), 16'(e != 0));
			check("cmppin", 16'(pin_out[0]), 16'(cmp_pin(2'(e), b)));
		end
		// Edge PWM: ch0 high-true, ch1 low-true, limit 9
		cfg.count_limit_value = 16'h0009;
		ch_cfg = {tpcu_ch_cfg_t'({2'h2, 2'h1}), tpcu_ch_cfg_t'({2'h2, 2'h2})};
		v = 16'h0001 + 16'($unsigned($random(seed)) % 8);
		w = 16'h0001 + 16'($unsigned($random(seed)) % 8);
		match = {w, v};
		ch_wr_en = 2'h3;
		cyc(1);
		ch_wr_en = 2'h0;
		restart();
		cyc(25);
		duty(0, 10, n);
		check("eduty", 16'(n), 16'(exp_high(1'b0, 1'b0, int'(v), 9)));
		check("lead", 16'(pin_out), 16'h0001);
		duty(1, 10, n);
		check("eduty1", 16'(n), 16'(exp_high(1'b0, 1'b1, int'(w), 9)));
		clr(0);
		wr(0, v + 16'h0001);
		check("held", ch_value[0], v);
		cyc(12);
		check("newval", ch_value[0], v + 16'h0001);
		check("pflag", 16'({flag[0], overflow_flag}), 16'h0003);
		// Center PWM, limit 8
		cfg.center_mode_select = 1'b1;
		cfg.count_limit_value = 16'h0008;
		v = 16'h0001 + 16'($unsigned($random(seed)) % 7);
		wr(0, v);
		restart();
		cyc(40);
		duty(0, 16, n);
		check("cduty", 16'(n), 16'(exp_high(1'b1, 1'b0, int'(v), 8)));
		check("coe", 16'(pin_oe), 16'h0003);
		// Counter off releases every pin
		cfg.count_clock_select = CLK_OFF;
		cyc(2);
		check("off", 16'(claim), 16'h0000);
		stop_test();
	end

	// Watchdog: scenarios need about 1100 cycles, allow far more
	initial begin
		cyc(20000);
		error_cnt++;
		stop_test();
	end
endmodule : tb_tpcu_top

/* dv/tpcu_pin_model.sv */
// Far side of the unit: signal sources on the channel pins and count clocks.
// Assumes the bench sets the source levels; clocks run free.
`timescale 1ns/10ps
module tpcu_pin_model
	import tpcu_pkg::*;
#(
	parameter int unsigned NUM_CH = 2
) (
	input  logic [NUM_CH-1:0] src_level,
	input  logic [NUM_CH-1:0] pin_out,
	input  logic [NUM_CH-1:0] pin_oe,
	output logic [NUM_CH-1:0] pin_wire,
	output logic              ext_clk,
	output logic              fix_clk
);
	// ==========================================================
	// Wire level: unit wins while it drives, else the source
	assign pin_wire = (pin_oe & pin_out) | (~pin_oe & src_level);

	// Count clocks well below a quarter of the bus rate, odd phase
	initial begin
		ext_clk = 1'b0;
		fix_clk = 1'b0;
		#7;
		fork
			forever #160 ext_clk = ~ext_clk; // 8 bus cycles
			forever #240 fix_clk = ~fix_clk; // 12 bus cycles
		join
	end
endmodule : tpcu_pin_model

/* dv/tpcu_top_sva.sv */
// Concurrent checks on the timer unit's top-level ports.
// Assumes one sys_clk domain; reset is asynchronous, active high.
`timescale 1ns/10ps
module tpcu_top_sva
	import tpcu_pkg::*;
#(
	parameter int unsigned NUM_CH = 8
) (
	input logic                      sys_clk,
	input logic                      reset,
	input logic                      clk_en,
	input logic                      debug_halt,
	input tpcu_cfg_t                 cfg,
	input logic                      count_write,
	input logic                      overflow_clr,
	input logic                      external_count_clock,
	input logic                      fixed_clock,
	input tpcu_ch_cfg_t [NUM_CH-1:0] ch_cfg,
	input logic [NUM_CH-1:0]         ch_wr_en,
	input logic [NUM_CH-1:0][15:0]   channel_match_value,
	input logic [NUM_CH-1:0]         ch_flag_clr,
	input logic [NUM_CH-1:0]         timer_channel_pin_in,
	input logic [15:0]               count_value,
	input logic                      count_down,
	input logic                      overflow_flag,
	input logic [NUM_CH-1:0][15:0]   ch_value,
	input logic [NUM_CH-1:0]         ch_flag,
	input logic [NUM_CH-1:0]         timer_channel_pin_out,
	input logic [NUM_CH-1:0]         timer_channel_pin_oe,
	input logic [NUM_CH-1:0]         timer_channel_pin_claim
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// ==========================================================
	// Helpers: effective limit; undivided bus-clock ticking only
	logic [15:0] lim;
	logic        run;
	assign lim = (cfg.count_limit_value == LIMIT_ZERO) ? LIMIT_FREE : cfg.count_limit_value;
	assign run = clk_en && !debug_halt && !count_write
		&& cfg.count_clock_select == CLK_BUS && cfg.prescale == 3'h0;

	// ==========================================================
	// Counter checks
	a_clken_freeze: assert property (
		!clk_en |=> $stable(count_value) && $stable(ch_flag))
		else $error("count or flags moved while clock enable low");
	a_debug_hold: assert property (debug_halt && !count_write |=> $stable(count_value))
		else $error("count moved during debug halt");
	a_write_clear: assert property (
		count_write && clk_en |=> count_value == CNT_RST && !count_down)
		else $error("counter write did not clear count");
	a_edge_step: assert property (
		run && !cfg.center_mode_select && count_value < lim
		|=> count_value == $past(count_value) + CNT_ONE)
		else $error("edge count did not step by one");
	a_edge_wrap: assert property (
		run && !cfg.center_mode_select && count_value == lim
		|=> count_value == CNT_RST && overflow_flag)
		else $error("edge count did not wrap with overflow");
	a_center_top: assert property (
		run && cfg.center_mode_select && count_value == lim
		|=> count_value == lim - CNT_ONE && overflow_flag && count_down)
		else $error("center count did not turn at limit");
	a_center_bottom: assert property (
		run && cfg.center_mode_select && count_value == CNT_RST |=> count_value == CNT_ONE)
		else $error("center count did not turn at zero");

	// ==========================================================
	// Pin ownership and flag checks
	a_claim_off: assert property (
		clk_en && cfg.count_clock_select == CLK_OFF |=> timer_channel_pin_claim == '0)
		else $error("pin still claimed with counter off");
	a_oe_claimed: assert property ((timer_channel_pin_oe & ~timer_channel_pin_claim) == '0)
		else $error("pin driven without being claimed");
	a_flag_sticky: assert property (ch_flag[0] && !ch_flag_clr[0] |=> ch_flag[0])
		else $error("channel flag dropped without clear");
	a_compare_hit: assert property (
		(clk_en && !cfg.center_mode_select && ch_cfg[0].mode == MODE_COMPARE
		&& !ch_wr_en[0] && !count_write)
		##1 (count_value != $past(count_value) && count_value == ch_value[0]) |-> ch_flag[0])
		else $error("compare match did not set flag");

	// Main scenarios reached
	c_center_turn: cover property ($rose(count_down));
	c_capture: cover property ($rose(ch_flag[1]));
	c_compare: cover property ($rose(ch_flag[0]) && ch_cfg[0].mode == MODE_COMPARE);
endmodule : tpcu_top_sva

bind tpcu_top tpcu_top_sva #(.NUM_CH(NUM_CH)) u_tpcu_top_sva (.sys_clk(sys_clk), .reset(reset),
	.clk_en(clk_en), .debug_halt(debug_halt), .cfg(cfg), .count_write(count_write),
	.overflow_clr(overflow_clr), .external_count_clock(external_count_clock),
	.fixed_clock(fixed_clock), .ch_cfg(ch_cfg), .ch_wr_en(ch_wr_en),
	.channel_match_value(channel_match_value), .ch_flag_clr(ch_flag_clr),
	.timer_channel_pin_in(timer_channel_pin_in), .count_value(count_value),
	.count_down(count_down), .overflow_flag(overflow_flag), .ch_value(ch_value),
	.ch_flag(ch_flag), .timer_channel_pin_out(timer_channel_pin_out),
	.timer_channel_pin_oe(timer_channel_pin_oe),
	.timer_channel_pin_claim(timer_channel_pin_claim));

/* logic/tpcu_channel.sv */
// One timer channel: capture, compare, edge PWM or center PWM.
// Assumes the counter step arrives from the top in the same cycle.
`timescale 1ns/10ps
module tpcu_channel
	import tpcu_pkg::*;
(
	input  logic         sys_clk,
	input  logic         reset,
	input  logic         clk_en,
	input  tpcu_ch_cfg_t cfg,
	input  tpcu_ev_t     ev,
	input  logic         pin_level,
	input  logic         pin_rise,
	input  logic         pin_fall,
	input  logic         wr_en,
	input  logic [15:0]  wr_data,
	input  logic         flag_clr,
	output logic [15:0]  value,
	output logic         flag,
	output logic         pin_out,
	output logic         pin_oe,
	output logic         pin_claim
);

	typedef struct packed {
		logic [15:0] value;
		logic [15:0] pend;
		logic        pend_v;
		logic        flag;
		logic        pin;
		logic        oe;
		logic        claim;
	} tpcu_ch_st_t;

	tpcu_ch_st_t s_q;
	tpcu_ch_st_t s_d;
	logic        fn_on;
	logic        pwm;
	logic        cap_mode;
	logic        cmp_mode;
	logic        cap_hit;
	logic        match;
	logic        active;
	logic        set_ev;

	// ==========================================================
	// Mode decode and event detection
	always_comb begin
		fn_on    = ev.enable && (cfg.edge_level != EDGE_NONE);
		pwm      = ev.center || cfg.mode[1];
		cap_mode = !ev.center && (cfg.mode == MODE_CAPTURE);
		cmp_mode = !ev.center && (cfg.mode == MODE_COMPARE);
		active   = !cfg.edge_level[0];
		match    = ev.tick && (ev.next == s_q.value);
		case (cfg.edge_level)
			EDGE_RISE: cap_hit = pin_rise;
			EDGE_FALL: cap_hit = pin_fall;
			EDGE_ANY:  cap_hit = pin_rise || pin_fall;
			default:   cap_hit = 1'b0;
		endcase
		cap_hit = cap_hit && cap_mode && ev.enable;
		// Compare flags even with no pin action, for software timing
		set_ev = cap_hit || (cmp_mode && match) || (pwm && fn_on && match);
	end

	// ==========================================================
	// Next state
	always_comb begin
		s_d       = s_q;
		s_d.claim = fn_on;
		s_d.oe    = fn_on && (ev.center || cfg.mode != MODE_CAPTURE);
		// Value write: direct outside PWM, buffered inside
		if (wr_en && pwm) begin
			s_d.pend   = wr_data;
			s_d.pend_v = 1'b1;
		end else if (wr_en) begin
			s_d.value = wr_data;
		end
		if (pwm && ev.load && s_d.pend_v) begin
			s_d.value  = s_d.pend;
			s_d.pend_v = 1'b0;
		end
		// Capture beats a same-cycle software write
		if (cap_hit) begin
			s_d.value = ev.cur;
		end
		// Set wins over clear
		s_d.flag = (s_q.flag && !flag_clr) || set_ev;
		// Undriven pin follows its level so toggle starts from it
		if (!s_q.oe) begin
			s_d.pin = pin_level;
		end
		if (cmp_mode && fn_on && match) begin
			case (cfg.edge_level)
				ACT_TOGGLE: s_d.pin = !s_q.pin;
				ACT_CLEAR:  s_d.pin = 1'b0;
				ACT_SET:    s_d.pin = 1'b1;
				default:    s_d.pin = s_q.pin;
			endcase
		end else if (ev.center && fn_on) begin
			if (match && !ev.up) begin
				s_d.pin = active;
			end else if (match) begin
				s_d.pin = !active;
			end
		end else if (pwm && fn_on) begin
			// Match before start gives a true 0% at value zero
			if (match) begin
				s_d.pin = !active;
			end else if (ev.start) begin
				s_d.pin = active;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_q       <= '0;
			s_q.value <= VAL_RST;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign value     = s_q.value;
	assign flag      = s_q.flag;
	assign pin_out   = s_q.pin;
	assign pin_oe    = s_q.oe;
	assign pin_claim = s_q.claim;

endmodule : tpcu_channel

/* logic/tpcu_pkg.sv */
// Constants and carrier types of the timer/PWM/capture unit.
// Assumes a single bus clock domain; pins are synchronised inside the unit.
package tpcu_pkg;

	// ==========================================================
	// Widths and reset values
	localparam int unsigned CNT_W      = 16;
	localparam int unsigned PRE_W      = 7;
	localparam logic [15:0] CNT_RST    = 16'h0000;
	localparam logic [15:0] VAL_RST    = 16'h0000;
	localparam logic [6:0]  PRE_RST    = 7'h00;
	localparam logic [15:0] LIMIT_ZERO = 16'h0000;
	localparam logic [15:0] LIMIT_FREE = 16'hffff;
	localparam logic [15:0] CNT_ONE    = 16'h0001;

	// ==========================================================
	// Count clock select encodings
	localparam logic [1:0] CLK_OFF   = 2'h0;
	localparam logic [1:0] CLK_BUS   = 2'h1;
	localparam logic [1:0] CLK_FIXED = 2'h2;
	localparam logic [1:0] CLK_EXT   = 2'h3;

	// ==========================================================
	// Channel mode; any mode with bit 1 set is edge-aligned PWM
	localparam logic [1:0] MODE_CAPTURE = 2'h0;
	localparam logic [1:0] MODE_COMPARE = 2'h1;

	// Edge selection (capture) and pin action (compare)
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_ANY  = 2'h3;
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic [1:0]  count_clock_select;
		logic [2:0]  prescale;
		logic        center_mode_select;
		logic [15:0] count_limit_value;
	} tpcu_cfg_t;

	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] edge_level;
	} tpcu_ch_cfg_t;

	// Counter step broadcast to every channel
	typedef struct packed {
		logic        enable;
		logic        center;
		logic        tick;
		logic        up;
		logic        load;
		logic        start;
		logic [15:0] cur;
		logic [15:0] next;
	} tpcu_ev_t;

endpackage : tpcu_pkg

/* logic/tpcu_sync.sv */
// Three-stage synchroniser with agreement filter and edge pulses.
// Assumes inputs are asynchronous to sys_clk and change slowly.
`timescale 1ns/10ps
module tpcu_sync
	import tpcu_pkg::*;
#(
	parameter int unsigned W = 1
) (
	input  logic         sys_clk,
	input  logic         reset,
	input  logic         clk_en,
	input  logic [W-1:0] din,
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] stable;
		logic [W-1:0] rise;
		logic [W-1:0] fall;
	} tpcu_sync_st_t;

	tpcu_sync_st_t s_q;
	tpcu_sync_st_t s_d;

	// ==========================================================
	// A change counts only once stages two and three agree
	always_comb begin
		s_d        = s_q;
		s_d.s1     = din;
		s_d.s2     = s_q.s1;
		s_d.s3     = s_q.s2;
		for (int i = 0; i < W; i++) begin
			if (s_q.s2[i] == s_q.s3[i]) begin
				s_d.stable[i] = s_q.s3[i];
			end
		end
		s_d.rise = s_d.stable & ~s_q.stable;
		s_d.fall = ~s_d.stable & s_q.stable;
	end

	// Frozen while the clock enable is low
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign level = s_q.stable;
	assign rise  = s_q.rise;
	assign fall  = s_q.fall;

endmodule : tpcu_sync

/* logic/tpcu_top.sv */
// Top of the timer/PWM/capture unit: shared counter, prescaler and
// count clock selection, plus one channel instance per pin.
// Assumes configuration arrives as plain ports held by the host logic,
// and that the port logic outside muxes pins by pin_claim / pin_oe.
`timescale 1ns/10ps

// Summary of operation
// - Channels individually pick capture, compare or edge PWM.
// - One center bit puts every channel into center PWM.
// - Debug state holds the counter; counting resumes afterwards.
// - Wait state: unit keeps counting, comparing and flagging.
// - Clock enable low freezes everything; resumes from held state.
// - Capture copies the counter into the channel value, sets flag.
// - Capture edge: rising, falling, either, or none (disabled).
// - Compare match sets flag and applies the pin action.
// - Compare action: clear, set, toggle, or leave pin alone.
// - Edge PWM period is limit plus one; value sets duty, polarity.
// - Edge PWM flags at period end and at the match that ends the duty.
// - Edge PWM leading edges share the common period start.
// - Center PWM period is twice the limit; value is half duty.
// - Center PWM counts up to limit, down to zero, repeat.
// - Center match counting down activates, counting up deactivates.
// - Limit 0x0000 or 0xffff makes the counter free running.
// - Reading the counter never disturbs counting.
// - Any counter write resets it, whatever the data.
// - One pin per channel, one to eight; optional external clock.
// - Pin without enabled function returns to port control.
// - After reset no function is enabled; pins stay port-controlled.
// - Clock from bus, synced fixed clock or external; divide 1..128.
// - One interrupt flag per channel plus terminal count flag.
// - PWM value updates only on the step to the limit.
module tpcu_top
	import tpcu_pkg::*;
#(
	parameter int unsigned NUM_CH = 8
) (
	input  logic                     sys_clk,
	input  logic                     reset,
	input  logic                     clk_en,
	input  logic                     debug_halt,
	input  tpcu_cfg_t                cfg,
	input  logic                     count_write,
	input  logic                     overflow_clr,
	input  logic                     external_count_clock,
	input  logic                     fixed_clock,
	input  tpcu_ch_cfg_t [NUM_CH-1:0] ch_cfg,
	input  logic [NUM_CH-1:0]        ch_wr_en,
	input  logic [NUM_CH-1:0][15:0]  channel_match_value,
	input  logic [NUM_CH-1:0]        ch_flag_clr,
	input  logic [NUM_CH-1:0]        timer_channel_pin_in,
	output logic [15:0]              count_value,
	output logic                     count_down,
	output logic                     overflow_flag,
	output logic [NUM_CH-1:0][15:0]  ch_value,
	output logic [NUM_CH-1:0]        ch_flag,
	output logic [NUM_CH-1:0]        timer_channel_pin_out,
	output logic [NUM_CH-1:0]        timer_channel_pin_oe,
	output logic [NUM_CH-1:0]        timer_channel_pin_claim
);

	localparam int unsigned SYNC_W = NUM_CH + 2;
	localparam int unsigned FIX_IX = NUM_CH;
	localparam int unsigned EXT_IX = NUM_CH + 1;

	typedef struct packed {
		logic [15:0] cnt;
		logic        down;
		logic [6:0]  pre;
		logic        ovf;
	} tpcu_top_st_t;

	tpcu_top_st_t       s_q;
	tpcu_top_st_t       s_d;
	tpcu_ev_t           ev;
	logic [15:0]        limit;
	logic               src_edge;
	logic               run;
	logic               tick;
	logic               top_hit;
	logic [6:0]         pre_mask;
	logic [SYNC_W-1:0]  sync_in;
	logic [SYNC_W-1:0]  sync_level;
	logic [SYNC_W-1:0]  sync_rise;
	logic [SYNC_W-1:0]  sync_fall;

	// ==========================================================
	// Input synchronisation
	// Channel pins, fixed clock and external clock share one bank.
	// The agreement filter adds latency, which is why the external
	// clock has to stay well below the bus rate.
	assign sync_in = {external_count_clock, fixed_clock, timer_channel_pin_in};

	tpcu_sync #(
		.W (SYNC_W)
	) u_sync (
		.sys_clk (sys_clk),
		.reset   (reset),
		.clk_en  (clk_en),
		.din     (sync_in),
		.level   (sync_level),
		.rise    (sync_rise),
		.fall    (sync_fall)
	);

	// ==========================================================
	// Count clock selection and prescaler
	always_comb begin
		case (cfg.count_clock_select)
			CLK_BUS:   src_edge = 1'b1;
			CLK_FIXED: src_edge = sync_rise[FIX_IX];
			CLK_EXT:   src_edge = sync_rise[EXT_IX];
			default:   src_edge = 1'b0;
		endcase
		// Debug halt stops the source; wait state has no input here
		run      = src_edge && !debug_halt;
		pre_mask = PRE_W'((8'h01 << cfg.prescale) - 8'h01);
		tick     = run && ((s_q.pre & pre_mask) == pre_mask);
	end

	// ==========================================================
	// Effective limit
	// Zero and all-ones both fall back to the full range.
	always_comb begin
		if (cfg.count_limit_value == LIMIT_ZERO) begin
			limit = LIMIT_FREE;
		end else begin
			limit = cfg.count_limit_value;
		end
		// Compare with >= so a lowered limit never strands the count
		top_hit = (s_q.cnt >= limit);
	end

	// ==========================================================
	// Counter, direction and overflow flag
	always_comb begin
		s_d = s_q;
		if (run) begin
			s_d.pre = s_q.pre + 7'h01;
		end
		if (count_write) begin
			// Data is ignored; the prescaler restarts as well
			s_d.cnt  = CNT_RST;
			s_d.down = 1'b0;
			s_d.pre  = PRE_RST;
		end else if (tick && cfg.center_mode_select) begin
			if (!s_q.down && top_hit) begin
				s_d.down = 1'b1;
				s_d.cnt  = s_q.cnt - CNT_ONE;
			end else if (!s_q.down) begin
				s_d.cnt = s_q.cnt + CNT_ONE;
			end else if (s_q.cnt == CNT_RST) begin
				s_d.down = 1'b0;
				s_d.cnt  = s_q.cnt + CNT_ONE;
			end else begin
				s_d.cnt = s_q.cnt - CNT_ONE;
			end
		end else if (tick) begin
			s_d.down = 1'b0;
			if (top_hit) begin
				s_d.cnt = CNT_RST;
			end else begin
				s_d.cnt = s_q.cnt + CNT_ONE;
			end
		end
		// Set wins over a same-cycle clear
		s_d.ovf = (s_q.ovf && !overflow_clr) ||
			(tick && !count_write && top_hit && !s_q.down);
	end

	// ==========================================================
	// Step broadcast to the channels
	// The value the channels match against is the count being entered,
	// so matches and the count output change on the same edge.
	always_comb begin
		ev        = '0;
		ev.enable = (cfg.count_clock_select != CLK_OFF);
		ev.center = cfg.center_mode_select;
		ev.tick   = tick && !count_write;
		ev.up     = !s_d.down;
		ev.cur    = s_q.cnt;
		ev.next   = s_d.cnt;
		// Buffered values land on the step into the limit
		ev.load   = ev.tick && !s_q.down && (s_q.cnt == limit - CNT_ONE);
		// Common period start for every edge PWM channel
		ev.start  = ev.tick && !cfg.center_mode_select && (s_d.cnt == CNT_RST);
	end

	// ==========================================================
	// State register
	// Clock enable low models stopped clocks: nothing advances.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_q      <= '0;
			s_q.cnt  <= CNT_RST;
			s_q.pre  <= PRE_RST;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// Plain register view; reading has no side effect
	assign count_value   = s_q.cnt;
	assign count_down    = s_q.down;
	assign overflow_flag = s_q.ovf;

	// ==========================================================
	// Channels
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		tpcu_channel u_ch (
			.sys_clk   (sys_clk),
			.reset     (reset),
			.clk_en    (clk_en),
			.cfg       (ch_cfg[c]),
			.ev        (ev),
			.pin_level (sync_level[c]),
			.pin_rise  (sync_rise[c]),
			.pin_fall  (sync_fall[c]),
			.wr_en     (ch_wr_en[c]),
			.wr_data   (channel_match_value[c]),
			.flag_clr  (ch_flag_clr[c]),
			.value     (ch_value[c]),
			.flag      (ch_flag[c]),
			.pin_out   (timer_channel_pin_out[c]),
			.pin_oe    (timer_channel_pin_oe[c]),
			.pin_claim (timer_channel_pin_claim[c])
		);
	end

endmodule : tpcu_top
